// File: hw/mic_pkg.sv
/*
  Package for the interrupt request block: source indices, vector numbers,
  edge-select encodings, timing counts and the port-group structs.
  Assumes a single 200 MHz clock domain.
*/
package mic_pkg;

  localparam int NUM_EXT      = 2;
  localparam int NUM_TMR      = 2;
  localparam int NUM_SRC      = 8;
  localparam int VEC_W        = 3;
  localparam int FLAG_W       = 13;
  localparam int PC_W         = 12;

  // source vector number, also priority order (0 highest); serial and low-supply share 7
  localparam logic [VEC_W-1:0] SRC_EXT0    = 3'h0;
  localparam logic [VEC_W-1:0] SRC_EXT1    = 3'h1;
  localparam logic [VEC_W-1:0] SRC_DATA_EP = 3'h2;
  localparam logic [VEC_W-1:0] SRC_SETUP   = 3'h3;
  localparam logic [VEC_W-1:0] SRC_CTRL_IN = 3'h4;
  localparam logic [VEC_W-1:0] SRC_CTRL_OT = 3'h5;
  localparam logic [VEC_W-1:0] SRC_SHARED  = 3'h6;
  localparam logic [VEC_W-1:0] SRC_SERIAL  = 3'h7;
  localparam logic [VEC_W-1:0] SRC_LOWSUP  = 3'h7;

  // edge-select setting encoding
  localparam logic [1:0] EDGE_OFF     = 2'h0;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;

  localparam logic       FLAG_RST     = 1'h0;
  localparam logic       GIE_RST      = 1'h0;
  localparam logic [1:0] EDGE_RST     = 2'h0;
  localparam int         SYNC_STAGES  = 2;

  typedef enum logic [1:0] {
    MIC_IDLE,
    MIC_PUSH,
    MIC_VECTOR
  } mic_state_e;

  // software access strobes from the core
  typedef struct packed {
    logic              gieSet;
    logic              gieClr;
    logic              irqExitReenable;
    logic [FLAG_W-1:0] flagSet;
    logic [FLAG_W-1:0] flagClr;
  } mic_sw_s;

  // per-source enables and edge settings
  typedef struct packed {
    logic [NUM_EXT-1:0]   extPinReqEnable;
    logic [2*NUM_EXT-1:0] edgeSelectSetting;
    logic                 dataEndpointReqEnable;
    logic                 setupTokenReqEnable;
    logic                 ctrlInTokenEnable;
    logic                 ctrlOutTokenEnable;
    logic                 sharedVectorEnable;
    logic                 serialByteReqEnable;
    logic                 lowSupplyReqEnable;
    logic [NUM_TMR-1:0]   timerMatchPEnable;
    logic [NUM_TMR-1:0]   timerMatchAEnable;
  } mic_en_s;

  // one-cycle events from peripheral logic on ref_clk
  typedef struct packed {
    logic               dataEndpointHit;
    logic               setupToken;
    logic               ctrlInToken;
    logic               ctrlOutToken;
    logic               serialByteDone;
    logic               lowSupply;
    logic [NUM_TMR-1:0] timerMatchP;
    logic [NUM_TMR-1:0] timerMatchA;
  } mic_evt_s;

  // flag vector bit positions
  localparam int F_EXT0   = 0;
  localparam int F_EXT1   = 1;
  localparam int F_DATA   = 2;
  localparam int F_SETUP  = 3;
  localparam int F_CIN    = 4;
  localparam int F_COUT   = 5;
  localparam int F_SHARED = 6;
  localparam int F_SERIAL = 7;
  localparam int F_LOWSUP = 8;
  localparam int F_TMR_P  = 9;
  localparam int F_TMR_A  = 11;

endpackage

// File: hw/mic_edge_detect.sv
/*
  Pin edge detector for the external interrupt pins: two-stage synchroniser
  then a selectable rising, falling or both edge pulse per pin.
  Assumes the pin is asynchronous to ref_clk.
*/
`timescale 1ns/1ps
module mic_edge_detect
  import mic_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rstSyncN,
  input  wire logic [NUM_EXT-1:0]   pinIn,
  input  wire logic [NUM_EXT-1:0]   pinEnable,
  input  wire logic [2*NUM_EXT-1:0] edgeSel,
  output logic      [NUM_EXT-1:0]   edgeHit
);

  logic [NUM_EXT-1:0] meta_q;
  logic [NUM_EXT-1:0] sync_q;
  logic [NUM_EXT-1:0] last_q;
  logic [NUM_EXT-1:0] meta_d;
  logic [NUM_EXT-1:0] sync_d;
  logic [NUM_EXT-1:0] last_d;
  logic [2:0]         warm_q;
  logic [2:0]         warm_d;

  always_comb
  begin
    meta_d = pinIn;
    sync_d = meta_q;
    last_d = sync_q;
    // edges count only once both compare stages hold real pin samples, so
    // a pin idling high through its pull-up gives no false edge after reset
    warm_d = {warm_q[1:0], 1'h1};
  end

  always_ff @(posedge ref_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
      warm_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
      warm_q <= warm_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++)
    begin : gPin
      logic rise;
      logic fall;
      logic [1:0] sel;
      assign sel  = edgeSel[2*g +: 2];
      assign rise = sync_q[g] & ~last_q[g];
      assign fall = ~sync_q[g] & last_q[g];
      // pin acts as interrupt input only while enabled [RQ4]
      assign edgeHit[g] = warm_q[2] & pinEnable[g] &
        (((sel == EDGE_RISE) & rise) | ((sel == EDGE_FALL) & fall) |
         ((sel == EDGE_BOTH) & (rise | fall))); // [RQ1] [RQ3]
    end
  endgenerate

endmodule

// File: hw/mic_irq_ctrl.sv
/*
  Interrupt request controller: request flags, enables, shared vector for
  timer matches, priority select, stack-full hold-off, vectoring handshake
  with the core and wake-up. Assumes the core raises a one-cycle
  serviceAck when it has taken the vector, then pushes the program counter on the pushPc_q pulse.
*/
`timescale 1ns/1ps
//Contract
//[RQ1] set pin flag on the selected edge of the pin
//[RQ2] vector pin interrupt only with global, pin enable and valid edge
//[RQ3] edge setting: rising, falling, both, or off
//[RQ4] pin is interrupt input only while its enable is set, as input
//[RQ5] pull-up selection stays in effect in interrupt use
//[RQ6] servicing clears source flag and global enable
//[RQ7] set data-endpoint flag on non-zero endpoint access
//[RQ8] set setup-token flag on endpoint-0 setup token
//[RQ9] set control-IN flag on endpoint-0 IN token
//[RQ10] set control-OUT flag on endpoint-0 OUT token
//[RQ11] set serial flag per byte sent or received
//[RQ12] set low-supply flag when detector reports low supply
//[RQ13] never vector while return stack is full
//[RQ14] set shared flag when any grouped timer flag becomes set
//[RQ15] each timer has P and A match flags and enables
//[RQ16] timer vector needs global, timer and shared enables
//[RQ17] servicing shared vector clears only the shared flag
//[RQ18] wake-up on any flag rising, enables ignored
//[RQ19] software presets a flag to block its wake-up
//[RQ20] flags hold until serviced or software clears
//[RQ21] only the program counter is pushed on entry
//[RQ22] interrupt return sets global enable, plain return does not
//[RQ23] software avoids calls inside handlers
//[RQ24] requests during a handler stay latched
//[RQ25] software re-enables global enable for nesting
//[RQ26] fixed priority picks one vector among pending requests
module mic_irq_ctrl
  import mic_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire logic [NUM_EXT-1:0]   extIrqPin,
  input  wire logic [NUM_EXT-1:0]   pinIsInput,
  input  wire logic [NUM_EXT-1:0]   pullUpSel,
  input  wire mic_en_s              enables,
  input  wire mic_evt_s             events,
  input  wire mic_sw_s              sw,
  input  wire logic                 stackFull,
  input  wire logic                 serviceAck,
  output logic                      irqReq_q,
  output logic [VEC_W-1:0]          irqVector_q,
  output logic                      pushPc_q,
  output logic                      globalIrqEnable_q,
  output logic [FLAG_W-1:0]         flags_q,
  output logic                      wakeUp_q,
  output logic [NUM_EXT-1:0]        pullUpEn_q
);

  ////////////////////////////////////////////////////////////////////////
  logic                  rstMeta_q;
  logic                  rstSyncN;
  logic [NUM_EXT-1:0]    extHit;
  logic [NUM_EXT-1:0]    pinActive;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta_q <= 1'h0;
      rstSyncN  <= 1'h0;
    end
    else
    begin
      rstMeta_q <= 1'h1;
      rstSyncN  <= rstMeta_q;
    end
  end

  // pin is used as interrupt input only when enabled and set as input
  assign pinActive = enables.extPinReqEnable & pinIsInput; // [RQ4]

  mic_edge_detect uEdge (
    .ref_clk   (ref_clk),
    .rstSyncN  (rstSyncN),
    .pinIn     (extIrqPin),
    .pinEnable (pinActive),
    .edgeSel   (enables.edgeSelectSetting),
    .edgeHit   (extHit)
  );

  ////////////////////////////////////////////////////////////////////////
  // flags
  logic [FLAG_W-1:0]  hwSet;
  logic [FLAG_W-1:0]  svcClr;
  logic [FLAG_W-1:0]  flags_d;
  logic [FLAG_W-1:0]  flagsPrev_q;
  logic [NUM_TMR-1:0] tmrReqP;
  logic [NUM_TMR-1:0] tmrReqA;
  logic               wakeUp_d;
  logic [NUM_EXT-1:0] pullUpEn_d;

  always_comb
  begin
    hwSet                  = '0;
    hwSet[F_EXT0]          = extHit[0]; // [RQ1]
    hwSet[F_EXT1]          = extHit[1]; // [RQ1]
    hwSet[F_DATA]          = events.dataEndpointHit; // [RQ7]
    hwSet[F_SETUP]         = events.setupToken; // [RQ8]
    hwSet[F_CIN]           = events.ctrlInToken; // [RQ9]
    hwSet[F_COUT]          = events.ctrlOutToken; // [RQ10]
    hwSet[F_SERIAL]        = events.serialByteDone; // [RQ11]
    hwSet[F_LOWSUP]        = events.lowSupply; // [RQ12]
    hwSet[F_TMR_P +: NUM_TMR] = events.timerMatchP; // [RQ15]
    hwSet[F_TMR_A +: NUM_TMR] = events.timerMatchA; // [RQ15]
    // a grouped timer flag that rises sets the shared flag too; taken from
    // the set sources, not flags_d, to keep the loop out of this logic
    hwSet[F_SHARED]        = |(({events.timerMatchA, events.timerMatchP} |
                               sw.flagSet[F_TMR_P +: 2*NUM_TMR]) &
                               ~flags_q[F_TMR_P +: 2*NUM_TMR]); // [RQ14]
  end

  // timer flags never appear in svcClr: only the shared flag clears
  // set wins over any clear so no event is lost
  genvar f;
  generate
    for (f = 0; f < FLAG_W; f++)
    begin : gFlag
      if (f == F_SHARED)
      begin : gSh
        logic tmrRise;
        assign tmrRise = hwSet[F_SHARED];
        assign flags_d[f] = tmrRise | (flags_q[f] & ~svcClr[f] &
          ~sw.flagClr[f]) | sw.flagSet[f]; // [RQ14] [RQ20]
      end
      else
      begin : gOt
        assign flags_d[f] = hwSet[f] | sw.flagSet[f] |
          (flags_q[f] & ~svcClr[f] & ~sw.flagClr[f]); // [RQ20] [RQ24]
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // request qualification and priority
  logic               anyReq;
  logic               tmrEnabled;
  logic [3:0]         pickIdx;

  always_comb
  begin
    tmrReqP    = flags_q[F_TMR_P +: NUM_TMR] & enables.timerMatchPEnable;
    tmrReqA    = flags_q[F_TMR_A +: NUM_TMR] & enables.timerMatchAEnable;
    tmrEnabled = |{tmrReqP, tmrReqA}; // [RQ16]
  end

  logic [8:0] reqVec;
  always_comb
  begin
    reqVec    = '0;
    // external request also needs a valid edge setting
    reqVec[0] = flags_q[F_EXT0] & enables.extPinReqEnable[0] &
                (enables.edgeSelectSetting[1:0] != EDGE_OFF); // [RQ2]
    reqVec[1] = flags_q[F_EXT1] & enables.extPinReqEnable[1] &
                (enables.edgeSelectSetting[3:2] != EDGE_OFF); // [RQ2]
    reqVec[2] = flags_q[F_DATA]   & enables.dataEndpointReqEnable;
    reqVec[3] = flags_q[F_SETUP]  & enables.setupTokenReqEnable;
    reqVec[4] = flags_q[F_CIN]    & enables.ctrlInTokenEnable;
    reqVec[5] = flags_q[F_COUT]   & enables.ctrlOutTokenEnable;
    reqVec[6] = flags_q[F_SHARED] & enables.sharedVectorEnable &
                tmrEnabled; // [RQ16]
    reqVec[7] = flags_q[F_SERIAL] & enables.serialByteReqEnable;
    reqVec[8] = flags_q[F_LOWSUP] & enables.lowSupplyReqEnable;
    pickIdx   = 4'h0;
    for (int i = 8; i >= 0; i--)
    begin
      if (reqVec[i])
      begin
        pickIdx = 4'(i); // [RQ26]
      end
    end
    anyReq = globalIrqEnable_q & ~stackFull & (|reqVec); // [RQ13]
  end

  ////////////////////////////////////////////////////////////////////////
  // vectoring handshake
  mic_state_e        state_q;
  mic_state_e        state_d;
  logic              gie_d;
  logic              irqReq_d;
  logic [VEC_W-1:0]  irqVector_d;
  logic              pushPc_d;
  logic [3:0]        srcIdx_q;
  logic [3:0]        srcIdx_d;

  always_comb
  begin
    state_d     = state_q;
    irqReq_d    = 1'h0;
    pushPc_d    = 1'h0;
    irqVector_d = irqVector_q;
    srcIdx_d    = srcIdx_q;
    svcClr      = '0;
    gie_d       = globalIrqEnable_q;
    case (state_q)
      MIC_IDLE:
      begin
        if (anyReq)
        begin
          srcIdx_d    = pickIdx;
          irqVector_d = pickIdx[VEC_W-1:0];
          if (pickIdx == 4'h8)
          begin
            irqVector_d = 3'h7;
          end
          irqReq_d = 1'h1;
          state_d  = MIC_PUSH;
        end
      end
      MIC_PUSH:
      begin
        irqReq_d = 1'h1;
        if (serviceAck)
        begin
          irqReq_d = 1'h0;
          pushPc_d = 1'h1; // [RQ21]
          gie_d    = 1'h0; // [RQ6]
          case (srcIdx_q)
            4'h0: svcClr[F_EXT0]   = 1'h1; // [RQ6]
            4'h1: svcClr[F_EXT1]   = 1'h1;
            4'h2: svcClr[F_DATA]   = 1'h1;
            4'h3: svcClr[F_SETUP]  = 1'h1;
            4'h4: svcClr[F_CIN]    = 1'h1;
            4'h5: svcClr[F_COUT]   = 1'h1;
            4'h6: svcClr[F_SHARED] = 1'h1; // [RQ17]
            4'h7: svcClr[F_SERIAL] = 1'h1;
            4'h8: svcClr[F_LOWSUP] = 1'h1;
            default: svcClr = '0;
          endcase
          state_d = MIC_VECTOR;
        end
      end
      MIC_VECTOR:
      begin
        state_d = MIC_IDLE;
      end
      default:
      begin
        state_d = MIC_IDLE;
      end
    endcase
    // irq exit re-enables; plain return leaves gie as is
    if (sw.irqExitReenable | sw.gieSet)
    begin
      gie_d = 1'h1; // [RQ22] [RQ25]
    end
    else if (sw.gieClr)
    begin
      gie_d = 1'h0;
    end
  end

  // wake on any flag rising, whatever the enables [RQ18]
  assign wakeUp_d   = |(flags_q & ~flagsPrev_q); // [RQ18]
  // pull-up selection passes through untouched in interrupt use
  assign pullUpEn_d = pullUpSel; // [RQ5]

  always_ff @(posedge ref_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state_q           <= MIC_IDLE;
      flags_q           <= '0;
      flagsPrev_q       <= '0;
      globalIrqEnable_q <= GIE_RST;
      irqReq_q          <= 1'h0;
      irqVector_q       <= '0;
      pushPc_q          <= 1'h0;
      srcIdx_q          <= 4'h0;
      wakeUp_q          <= 1'h0;
      pullUpEn_q        <= '0;
    end
    else
    begin
      state_q           <= state_d;
      flags_q           <= flags_d;
      flagsPrev_q       <= flags_q;
      globalIrqEnable_q <= gie_d;
      irqReq_q          <= irqReq_d;
      irqVector_q       <= irqVector_d;
      pushPc_q          <= pushPc_d;
      srcIdx_q          <= srcIdx_d;
      wakeUp_q          <= wakeUp_d;
      pullUpEn_q        <= pullUpEn_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  chk_stack_full_block: assert property (@(posedge ref_clk) // [RQ13]
    disable iff (!rstSyncN)
    (state_q == MIC_IDLE && stackFull) |=> !irqReq_q)
    else $error("vector request raised while stack full");

  chk_gie_gate: assert property (@(posedge ref_clk) // [RQ2]
    disable iff (!rstSyncN)
    (state_q == MIC_IDLE && !globalIrqEnable_q) |=> !irqReq_q)
    else $error("vector request without global enable");

  chk_svc_gie_clr: assert property (@(posedge ref_clk) // [RQ6]
    disable iff (!rstSyncN)
    (state_q == MIC_PUSH && serviceAck && !sw.gieSet &&
     !sw.irqExitReenable) |=> !globalIrqEnable_q && pushPc_q)
    else $error("service did not clear global enable");

  chk_exit_reenable: assert property (@(posedge ref_clk) // [RQ22]
    disable iff (!rstSyncN)
    sw.irqExitReenable |=> globalIrqEnable_q)
    else $error("irq exit did not set global enable");

  chk_flag_hold: assert property (@(posedge ref_clk) // [RQ20]
    disable iff (!rstSyncN)
    (flags_q[F_LOWSUP] && !sw.flagClr[F_LOWSUP] && !svcClr[F_LOWSUP])
    |=> flags_q[F_LOWSUP])
    else $error("low-supply flag dropped without clear");

  chk_timer_keep: assert property (@(posedge ref_clk) // [RQ17]
    disable iff (!rstSyncN)
    (flags_q[F_TMR_P] && !sw.flagClr[F_TMR_P]) |=> flags_q[F_TMR_P])
    else $error("timer flag cleared by service");

  chk_shared_set: assert property (@(posedge ref_clk) // [RQ14]
    disable iff (!rstSyncN)
    (events.timerMatchA[0] && !flags_q[F_TMR_A]) |=> flags_q[F_SHARED])
    else $error("shared flag not set on timer match");

  chk_wake_rise: assert property (@(posedge ref_clk) // [RQ18]
    disable iff (!rstSyncN)
    (events.serialByteDone && !flags_q[F_SERIAL]) |-> ##2 wakeUp_q)
    else $error("no wake-up on flag rise");

  chk_event_flag: assert property (@(posedge ref_clk) // [RQ12]
    disable iff (!rstSyncN)
    events.lowSupply |=> flags_q[F_LOWSUP])
    else $error("low-supply event lost");

endmodule

// File: dv/mic_core_model.sv
/*
  Behavioural core model: takes vector requests after a set delay, keeps
  a return-stack depth and reports it full.
  Assumes one ref_clk domain and the active-low reset of the bench.
*/
`timescale 1ns/1ps
module mic_core_model
#(
  parameter int DEPTH = 1
)
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       irqReq_q,
  input  wire logic       pushPc_q,
  input  wire logic       popReq,
  input  wire logic [3:0] ackDelay,
  output logic            serviceAck,
  output logic            stackFull
);
  int   depth;
  int   waitCnt;
  logic busy;
  ////////////////////
  assign stackFull = (depth >= DEPTH);
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      depth <= 0;
      waitCnt <= 0;
      busy <= 1'h0;
      serviceAck <= 1'h0;
    end
    else
    begin
      serviceAck <= 1'h0;
      if (!irqReq_q)
        busy <= 1'h0;
      else if (!busy && waitCnt >= ackDelay)
      begin
        serviceAck <= 1'h1;
        busy <= 1'h1;
        waitCnt <= 0;
      end
      else if (!busy)
        waitCnt <= waitCnt + 1;
      // one entry per taken vector, no calls from handlers; a return that
      // meets the push pulse in one cycle leaves the depth unchanged
      if (pushPc_q && !popReq)
        depth <= depth + 1;
      else if (popReq && !pushPc_q && depth > 0)
        depth <= depth - 1;
    end
  end
endmodule

// File: dv/tb_mic_irq_ctrl.sv
/*
  Self-checking bench for the interrupt request controller: source table,
  pin edges, stack full, priority and wake-up.
  Assumes the core model in its own file and the package constants.
*/
`timescale 1ns/1ps
module tb_mic_irq_ctrl
  import mic_pkg::*;
;
  typedef struct {
    mic_evt_s          evt;
    mic_en_s           en;
    logic [VEC_W-1:0]  vec;
    logic [FLAG_W-1:0] seen;
    logic [FLAG_W-1:0] after;
  } mic_row_s;
  logic              ref_clk;
  logic              nrst;
  logic [1:0]        extIrqPin;
  logic [1:0]        pinIsInput;
  logic [1:0]        pullUpSel;
  mic_en_s           enables;
  mic_evt_s          events;
  mic_sw_s           sw;
  logic              stackFull;
  logic              serviceAck;
  logic              popReq;
  logic [3:0]        ackDelay;
  logic              irqReq_q;
  logic [VEC_W-1:0]  irqVector_q;
  logic              pushPc_q;
  logic              globalIrqEnable_q;
  logic [FLAG_W-1:0] flags_q;
  logic              wakeUp_q;
  logic [1:0]        pullUpEn_q;
  int                miscompares;
  int                checks;
  int                wakeCount;
  mic_row_s          rows[8];
  ////////////////////
  mic_irq_ctrl mic_irq_ctrl_inst (.ref_clk(ref_clk), .nrst(nrst),
    .extIrqPin(extIrqPin), .pinIsInput(pinIsInput), .pullUpSel(pullUpSel),
    .enables(enables), .events(events), .sw(sw), .stackFull(stackFull),
    .serviceAck(serviceAck), .irqReq_q(irqReq_q), .irqVector_q(irqVector_q),
    .pushPc_q(pushPc_q), .globalIrqEnable_q(globalIrqEnable_q),
    .flags_q(flags_q), .wakeUp_q(wakeUp_q), .pullUpEn_q(pullUpEn_q));
  mic_core_model #(.DEPTH(1)) mic_core_model_inst (.ref_clk(ref_clk),
    .nrst(nrst), .irqReq_q(irqReq_q), .pushPc_q(pushPc_q), .popReq(popReq),
    .ackDelay(ackDelay), .serviceAck(serviceAck), .stackFull(stackFull));
  ////////////////////
  initial
  begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (wakeUp_q === 1'h1)
      wakeCount++;
  ////////////////////
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic pulseEvt(input mic_evt_s e);
    events = e;
    tick();
    events = '0;
  endtask
  task automatic gieOn();
    sw.gieSet = 1'h1;
    tick();
    sw = '0;
  endtask
  task automatic clrAll();
    sw.flagClr = 13'h1fff;
    tick();
    sw = '0;
  endtask
  task automatic plainRet();
    popReq = 1'h1;
    tick();
    popReq = 1'h0;
  endtask
  // bounded wait for the request (0) or the push pulse (1)
  task automatic waitHi(input bit push);
    int i;
    for (i = 0; i < 20 && (push ? pushPc_q : irqReq_q) !== 1'h1; i++)
      tick();
    chk(push ? "pushPc_q" : "irqReq_q", 16'h1, push ? pushPc_q : irqReq_q);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////
  initial
  begin
    #50000;
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    int m;
    int w0;
    rows[0] = '{10'h200, 17'h00400, SRC_DATA_EP, 13'h0004, 13'h0000};
    rows[1] = '{10'h100, 17'h00200, SRC_SETUP, 13'h0008, 13'h0000};
    rows[2] = '{10'h080, 17'h00100, SRC_CTRL_IN, 13'h0010, 13'h0000};
    rows[3] = '{10'h040, 17'h00080, SRC_CTRL_OT, 13'h0020, 13'h0000};
    rows[4] = '{10'h020, 17'h00020, SRC_SERIAL, 13'h0080, 13'h0000};
    rows[5] = '{10'h010, 17'h00010, SRC_LOWSUP, 13'h0100, 13'h0000};
    rows[6] = '{10'h004, 17'h00044, SRC_SHARED, 13'h0240, 13'h0200};
    rows[7] = '{10'h002, 17'h00042, SRC_SHARED, 13'h1040, 13'h1000};
    nrst = 1'h0;
    extIrqPin = 2'h0;
    pinIsInput = 2'h0;
    pullUpSel = 2'h0;
    enables = '0;
    events = '0;
    sw = '0;
    popReq = 1'h0;
    ackDelay = 4'h0;
    miscompares = 0;
    checks = 0;
    wakeCount = 0;
    tick(16);
    chk("flags_q in reset", 16'h0, flags_q);
    chk("gie in reset", 16'(GIE_RST), globalIrqEnable_q);
    nrst = 1'h1;
    tick(3);
    foreach (rows[i])
    begin
      ackDelay = 4'(i);
      enables = rows[i].en;
      gieOn();
      w0 = wakeCount;
      pulseEvt(rows[i].evt);
      waitHi(1'b0);
      chk("irqVector_q", rows[i].vec, irqVector_q);
      chk("flags_q", rows[i].seen, flags_q);
      waitHi(1'b1);
      chk("irqReq_q at push", 16'h0, irqReq_q);
      chk("gie at push", 16'h0, globalIrqEnable_q);
      chk("flags_q at push", rows[i].after, flags_q);
      chk("wake pulse", 16'h1, wakeCount != w0);
      sw.irqExitReenable = 1'h1;
      popReq = 1'h1;
      tick();
      sw = '0;
      popReq = 1'h0;
      chk("gie after exit", 16'h1, globalIrqEnable_q);
      clrAll();
    end
    ackDelay = 4'h2;
    pinIsInput = 2'h1;
    pullUpSel = 2'h2;
    enables = '0;
    enables.extPinReqEnable = 2'h1;
    sw.gieClr = 1'h1;
    tick();
    sw = '0;
    for (m = 0; m < 4; m++)
    begin
      enables.edgeSelectSetting = 4'(m);
      extIrqPin[0] = 1'h1;
      tick(8);
      chk("pin flag rise", 16'(m % 2), flags_q[F_EXT0]);
      clrAll();
      extIrqPin[0] = 1'h0;
      tick(8);
      chk("pin flag fall", 16'(m / 2), flags_q[F_EXT0]);
      clrAll();
    end
    chk("pullUpEn_q", 16'h2, pullUpEn_q);
    pinIsInput = 2'h0;
    extIrqPin[0] = 1'h1;
    tick(8);
    chk("pin flag not input", 16'h0, flags_q[F_EXT0]);
    pinIsInput = 2'h1;
    extIrqPin[0] = 1'h0;
    enables.edgeSelectSetting = EDGE_OFF;
    sw.flagSet = 13'h0001;
    tick();
    sw = '0;
    gieOn();
    tick(8);
    chk("irqReq_q edge off", 16'h0, irqReq_q);
    clrAll();
    enables.edgeSelectSetting = EDGE_RISE;
    sw.gieClr = 1'h1;
    tick();
    sw = '0;
    extIrqPin[0] = 1'h1;
    tick(12);
    chk("irqReq_q gie off", 16'h0, irqReq_q);
    chk("pin flag held", 16'h1, flags_q[F_EXT0]);
    gieOn();
    waitHi(1'b0);
    chk("irqVector_q pin", 16'(SRC_EXT0), irqVector_q);
    waitHi(1'b1);
    chk("pin flag at push", 16'h0, flags_q[F_EXT0]);
    enables = '0;
    enables.setupTokenReqEnable = 1'h1;
    pulseEvt(10'h100);
    tick(4);
    chk("setup flag latched", 16'h1, flags_q[F_SETUP]);
    gieOn();
    tick(8);
    chk("irqReq_q stack full", 16'h0, irqReq_q);
    plainRet();
    waitHi(1'b0);
    chk("irqVector_q after pop", 16'(SRC_SETUP), irqVector_q);
    waitHi(1'b1);
    plainRet();
    tick(3);
    chk("gie after plain return", 16'h0, globalIrqEnable_q);
    enables = 17'h00330;
    pulseEvt(10'h1b0);
    foreach (rows[i])
      if (i == 1 || i == 2 || i == 4 || i == 5)
      begin
        gieOn();
        waitHi(1'b0);
        chk("irqVector_q priority", rows[i].vec, irqVector_q);
        waitHi(1'b1);
        plainRet();
      end
    chk("flags_q drained", 16'h0, flags_q);
    sw.flagSet = 13'h0080;
    tick();
    sw = '0;
    tick(4);
    w0 = wakeCount;
    pulseEvt(10'h020);
    tick(4);
    chk("wake blocked", 16'h0, wakeCount != w0);
    tally_and_finish();
  end
endmodule
